// File: verilog/pic_defines.svh
// constants of the prioritized interrupt controller: offsets, fields, resets, timing
// assumes a 16-bit register port with word indices, one 250 MHz clock
// How it works
// - nesting disable bit 15 of control 1 stops preemption of a routine in service by any level below 8; traps still preempt.
// - reset sets every user source priority field to level 4.
// - only a source with its enable bit set may request the core.
// - flag stays until software clears it; still set, it requests again at once.
// - return restores saved program counter, status low byte and previous priority level.
// - trap flag in control 1 keeps the trap asserted until software clears it.
// - global enable in control 2 allows user interrupts; cleared, it blocks them.
// - only levels up to 7 are maskable; traps at level 15 taken whenever the core level is below 15.
// - timed disable masks levels 1 to 6 for a fixed time, never 7 or traps.
// - reset values: control 2 8000, priorities 4444, all others 0000.
// - priority register holds four 3-bit fields; bits 15, 11, 7, 3 read zero.
// - a source's flag and enable bits sit at the same position of same-numbered registers.
// - priority code 111 is level 7, 001 level 1, 000 disables the source.
// - among equal priorities the lowest vector number wins.
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define PIC_IDX_CTRL1    6'h00
`define PIC_IDX_CTRL2    6'h01
`define PIC_IDX_CTRL3    6'h02
`define PIC_IDX_CTRL4    6'h03
`define PIC_IDX_FLAG0    6'h04
`define PIC_IDX_ENA0     6'h0d
`define PIC_IDX_PRI0     6'h16
`define PIC_IDX_IRQST    6'h1f
`define PIC_IDX_IRQMSK   6'h20
`define PIC_IDX_CORE     6'h21
// ----------------------------------------
// fields
// ----------------------------------------
`define PIC_CTRL1_NSTD   15
`define PIC_CTRL1_TRAPS  14:1
`define PIC_CTRL1_WMASK  16'h8000
`define PIC_CTRL2_GIE    15
`define PIC_CTRL2_TDIS   14
`define PIC_CTRL2_SWTRAP 13
`define PIC_CTRL2_WMASK  16'ha01f
`define PIC_CTRL3_WMASK  16'h0070
`define PIC_CTRL4_WMASK  16'h0001
`define PIC_PRI_WMASK    16'h7777
// ----------------------------------------
// reset values
// ----------------------------------------
`define PIC_RST_CTRL2    16'h8000
`define PIC_RST_PRI      16'h4444
`define PIC_RST_ZERO     16'h0000
// ----------------------------------------
// timing
// ----------------------------------------
`define PIC_TDIS_CYCLES  14'h0010
`endif

// File: verilog/pic_pkg.sv
// types of the prioritized interrupt controller
// shared by the core block and its register store
package pic_pkg;
  typedef logic [15:0] pic_word_t;
  typedef logic [3:0]  pic_lvl_t;
  typedef struct packed {
    logic      valid;
    pic_lvl_t  level;
    logic [7:0] vector;
  } pic_req_s;
  typedef enum logic [2:0] {
    PIC_IDLE = 3'b001,
    PIC_REQ  = 3'b010,
    PIC_ACK  = 3'b100
  } pic_state_e;
endpackage

// File: verilog/pic_store.sv
// small register memory for priority words, read data registered
// assumes one write and one read port, synchronous
`timescale 1ns/1ns
`include "pic_defines.svh"
module pic_store
  import pic_pkg::*;
#(
  parameter int DEPTH = 9
)(
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire pic_word_t                i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output pic_word_t                     o_rdata,
  output pic_word_t                     o_all [DEPTH]
);
  pic_word_t mem [DEPTH];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_w
      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
          mem[g] <= `PIC_RST_PRI;
        else if (i_we && i_waddr == g)
          mem[g] <= i_wdata & `PIC_PRI_WMASK;
      end
      assign o_all[g] = mem[g];
    end
  endgenerate
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= `PIC_RST_ZERO;
    else
      o_rdata <= (i_raddr < DEPTH) ? mem[i_raddr] : `PIC_RST_ZERO;
  end
endmodule

// File: verilog/pic_ctrl.sv
// prioritized interrupt controller: flags, enables, priorities, arbitration
// assumes synchronous peripheral pulses and a core that acks, returns, executes timed disable
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "pic_defines.svh"
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int NREG    = 9,
  parameter int TDIS_CY = `PIC_TDIS_CYCLES
)(
  // clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  // register port
  input  wire logic [5:0]        I_ADDR,
  input  wire pic_word_t         I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output pic_word_t              O_RDATA,
  // peripheral sources and traps
  input  wire logic [NREG*16-1:0] I_SRC,
  input  wire logic [13:0]       I_TRAP,
  // core side
  input  wire logic              I_ACK,
  input  wire logic              I_RETURN,
  input  wire logic              I_TDIS,
  input  wire logic [23:0]       I_SAVE_PC,
  input  wire logic [7:0]        I_SAVE_SRL,
  output pic_req_s               O_REQ,
  output pic_lvl_t               O_CPU_LEVEL,
  output logic [23:0]            O_RET_PC,
  output logic [7:0]             O_RET_SRL,
  output logic                   O_RET_VALID,
  // interrupt line
  output logic                   O_IRQ
);
  localparam int NSRC = NREG * 16;
  localparam int PW   = $clog2(NREG);
  localparam int SD   = 8;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  pic_word_t  ctrl1;
  pic_word_t  ctrl2;
  pic_word_t  ctrl3;
  pic_word_t  ctrl4;
  pic_word_t  flag [NREG];
  pic_word_t  ena  [NREG];
  pic_word_t  pri  [NREG];
  pic_word_t  pri_rd;
  pic_word_t  rd_q;
  logic       rd_pri_q;
  logic [2:0] irq_st;
  logic [2:0] irq_msk;
  logic [13:0] tdis_cnt;
  pic_lvl_t   cpu_lvl;
  pic_state_e state;
  logic [2:0] sp;
  // stack words carry no reset: only entries below sp are ever read
  logic [35:0] stack [SD];
  pic_req_s   best;
  logic       trap_any;
  logic       wr_pri;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] base, input int n);
    hit = (a >= base) && (a < base + 6'(n));
  endfunction

  // only NREG priority words exist; sources past 4*NREG share them
  function automatic pic_lvl_t fld(input int s);
    pic_word_t w;
    w = pri[(s / 4) % NREG];
    fld = {1'b0, w[(s % 4) * 4 +: 3]};
  endfunction

  assign wr_pri = I_WR && hit(I_ADDR, `PIC_IDX_PRI0, NREG);

  pic_store #(.DEPTH(NREG)) u_store (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_we    (wr_pri),
    .i_waddr (PW'(I_ADDR - `PIC_IDX_PRI0)),
    .i_wdata (I_WDATA),
    .i_raddr (PW'(I_ADDR - `PIC_IDX_PRI0)),
    .o_rdata (pri_rd),
    .o_all   (pri)
  );

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      ctrl1 <= `PIC_RST_ZERO;
      ctrl2 <= `PIC_RST_CTRL2;
      ctrl3 <= `PIC_RST_ZERO;
      ctrl4 <= `PIC_RST_ZERO;
    end
    else
    begin
      // trap flags: set wins over clear, held until software clears
      if (I_WR && I_ADDR == `PIC_IDX_CTRL1)
        ctrl1 <= (I_WDATA & (`PIC_CTRL1_WMASK | 16'h7ffe)) | {1'b0, I_TRAP, 1'b0};
      else
        ctrl1 <= ctrl1 | {1'b0, I_TRAP, 1'b0};
      if (I_WR && I_ADDR == `PIC_IDX_CTRL2)
        ctrl2 <= (I_WDATA & `PIC_CTRL2_WMASK) | {1'b0, tdis_cnt != 14'h0, 14'h0};
      else
        ctrl2[`PIC_CTRL2_TDIS] <= (tdis_cnt != 14'h0);
      if (I_WR && I_ADDR == `PIC_IDX_CTRL3)
        ctrl3 <= I_WDATA & `PIC_CTRL3_WMASK;
      if (I_WR && I_ADDR == `PIC_IDX_CTRL4)
        ctrl4 <= I_WDATA & `PIC_CTRL4_WMASK;
    end
  end

  // ----------------------------------------
  // flags and enables
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_fe
      always_ff @(posedge I_CLK or posedge I_RST)
      begin
        if (I_RST)
        begin
          flag[g] <= `PIC_RST_ZERO;
          ena[g]  <= `PIC_RST_ZERO;
        end
        else
        begin
          // sticky until software clears; a source event wins over the clear
          if (I_WR && I_ADDR == `PIC_IDX_FLAG0 + 6'(g))
            flag[g] <= I_WDATA | I_SRC[g*16 +: 16];
          else
            flag[g] <= flag[g] | I_SRC[g*16 +: 16];
          if (I_WR && I_ADDR == `PIC_IDX_ENA0 + 6'(g))
            ena[g] <= I_WDATA;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  always_comb
  begin
    pic_lvl_t lv;
    logic     gate;
    best = '0;
    lv   = '0;
    gate = 1'b0;
    // traps come first, always unmaskable
    trap_any = |ctrl1[`PIC_CTRL1_TRAPS] | ctrl4[0] | ctrl2[`PIC_CTRL2_SWTRAP];
    if (trap_any)
    begin
      best.valid  = 1'b1;
      best.level  = 4'hf;
      best.vector = 8'h00;
    end
    else
    begin
      // descending scan so the lowest vector wins a tie
      for (int s = NSRC - 1; s >= 0; s--)
      begin
        lv   = fld(s);
        gate = flag[s / 16][s % 16] && ena[s / 16][s % 16]
               && lv != 4'h0
               && ctrl2[`PIC_CTRL2_GIE]
               && !(tdis_cnt != 14'h0 && lv < 4'h7);
        if (gate && lv >= best.level)
        begin
          best.valid  = 1'b1;
          best.level  = lv;
          best.vector = 8'(s + 8);
        end
      end
    end
    // forward only above the current core level, nesting rules
    if (best.valid && best.level <= cpu_lvl)
      best.valid = 1'b0;
    // nesting off: all below trap level waits until the routine ends
    if (best.valid && ctrl1[`PIC_CTRL1_NSTD] && cpu_lvl != 4'h0 && best.level < 4'h8)
      best.valid = 1'b0;
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      O_REQ <= '0;
    else
      O_REQ <= best;
  end

  // ----------------------------------------
  // core level, stack and handshake
  // ----------------------------------------
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cpu_lvl     <= '0;
      sp          <= '0;
      state       <= PIC_IDLE;
      O_RET_PC    <= '0;
      O_RET_SRL   <= '0;
      O_RET_VALID <= 1'b0;
    end
    else
    begin
      O_RET_VALID <= 1'b0;
      case (state)
        // an ack in the first cycle of a request counts as well, so none is lost
        PIC_IDLE, PIC_REQ:
          if (I_ACK && O_REQ.valid)
          begin
            stack[sp] <= {I_SAVE_PC, I_SAVE_SRL, cpu_lvl};
            sp        <= sp + 3'h1;
            cpu_lvl   <= O_REQ.level;
            state     <= PIC_ACK;
          end
          else if (O_REQ.valid)
            state <= PIC_REQ;
          else
            state <= PIC_IDLE;
        PIC_ACK:
          state <= PIC_IDLE;
        default:
          state <= PIC_IDLE;
      endcase
      // a return pops pc, status low byte and old level
      // limitation: a return in the cycle right after an ack is ignored
      if (I_RETURN && sp != 3'h0 && state != PIC_ACK)
      begin
        sp          <= sp - 3'h1;
        O_RET_PC    <= stack[sp - 3'h1][35:12];
        O_RET_SRL   <= stack[sp - 3'h1][11:4];
        cpu_lvl     <= stack[sp - 3'h1][3:0];
        O_RET_VALID <= 1'b1;
      end
    end
  end
  assign O_CPU_LEVEL = cpu_lvl;

  // ----------------------------------------
  // timed disable counter
  // ----------------------------------------
  // a new timed disable restarts the count; it never extends it
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      tdis_cnt <= '0;
    else if (I_TDIS)
      tdis_cnt <= 14'(TDIS_CY);
    else if (tdis_cnt != 14'h0)
      tdis_cnt <= tdis_cnt - 14'h1;
  end

  // ----------------------------------------
  // sticky events: trap, request, return
  // ----------------------------------------
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      irq_st  <= '0;
      irq_msk <= '0;
    end
    else
    begin
      if (I_WR && I_ADDR == `PIC_IDX_IRQST)
        irq_st <= (irq_st & ~I_WDATA[2:0]) | {O_RET_VALID, best.valid, trap_any};
      else
        irq_st <= irq_st | {O_RET_VALID, best.valid, trap_any};
      if (I_WR && I_ADDR == `PIC_IDX_IRQMSK)
        irq_msk <= I_WDATA[2:0];
    end
  end
  assign O_IRQ = |(irq_st & irq_msk);

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      rd_q     <= '0;
      rd_pri_q <= 1'b0;
    end
    else
    begin
      rd_pri_q <= I_RD && hit(I_ADDR, `PIC_IDX_PRI0, NREG);
      rd_q     <= '0;
      if (I_RD)
      begin
        if (I_ADDR == `PIC_IDX_CTRL1)
          rd_q <= ctrl1;
        else if (I_ADDR == `PIC_IDX_CTRL2)
          rd_q <= ctrl2;
        else if (I_ADDR == `PIC_IDX_CTRL3)
          rd_q <= ctrl3;
        else if (I_ADDR == `PIC_IDX_CTRL4)
          rd_q <= ctrl4;
        else if (hit(I_ADDR, `PIC_IDX_FLAG0, NREG))
          rd_q <= flag[PW'(I_ADDR - `PIC_IDX_FLAG0)];
        else if (hit(I_ADDR, `PIC_IDX_ENA0, NREG))
          rd_q <= ena[PW'(I_ADDR - `PIC_IDX_ENA0)];
        else if (I_ADDR == `PIC_IDX_IRQST)
          rd_q <= {13'h0, irq_st};
        else if (I_ADDR == `PIC_IDX_IRQMSK)
          rd_q <= {13'h0, irq_msk};
        else if (I_ADDR == `PIC_IDX_CORE)
          rd_q <= {4'h0, cpu_lvl, O_REQ.vector};
      end
    end
  end
  // priority words come registered from the store, not from rd_q, hence the select flag
  assign O_RDATA = rd_pri_q ? pri_rd : rd_q;
endmodule

// File: test/pic_ctrl_monitor.sv
// port checker of the interrupt controller
// assumes one clock, async high reset, bound to pic_ctrl
`timescale 1ns/1ns
`include "pic_defines.svh"
module pic_ctrl_monitor
  import pic_pkg::*;
(
  // watched ports
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic [5:0]  I_ADDR,
  input wire pic_word_t   I_WDATA,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire pic_word_t   O_RDATA,
  input wire logic [13:0] I_TRAP,
  input wire logic        I_ACK,
  input wire logic        I_RETURN,
  input wire logic        I_TDIS,
  input wire pic_req_s    O_REQ,
  input wire pic_lvl_t    O_CPU_LEVEL,
  input wire logic        O_RET_VALID
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence ret_done_s;
    O_RET_VALID ##1 !O_RET_VALID;
  endsequence
  sequence trap_req_s;
    O_REQ.valid && O_REQ.level == 4'hf;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  pri_gaps_a: assert property (I_RD && I_ADDR >= `PIC_IDX_PRI0 && I_ADDR < `PIC_IDX_IRQST
    |=> (O_RDATA & 16'h8888) == 16'h0000) else $error("priority gap bit set");
  unmapped_zero_a: assert property (I_RD && I_ADDR > `PIC_IDX_CORE
    |=> O_RDATA == 16'h0000) else $error("unmapped read not zero");
  trap_taken_a: assert property (|I_TRAP && O_CPU_LEVEL != 4'hf |-> ##2 trap_req_s)
    else $error("trap not requested");
  level_gate_a: assert property (O_REQ.valid && !$past(I_ACK)
    |-> O_REQ.level > O_CPU_LEVEL) else $error("request not above core level");
  ack_level_a: assert property (I_ACK && O_REQ.valid
    |=> O_CPU_LEVEL == $past(O_REQ.level)) else $error("core level not taken");
  ret_pulse_a: assert property (I_RETURN |=> ret_done_s)
    else $error("return pulse wrong");
  tdis_mask_a: assert property (I_TDIS |-> ##2 (!O_REQ.valid || O_REQ.level > 4'h6)[*8])
    else $error("timed disable leaked");
  gie_block_a: assert property (I_WR && I_ADDR == `PIC_IDX_CTRL2 && !I_WDATA[15]
    |-> ##2 (!O_REQ.valid || O_REQ.level[3])[*4]) else $error("user request with enable off");
  zero_level_a: assert property (O_REQ.valid |-> O_REQ.level != 4'h0)
    else $error("zero level requested");
endmodule
bind pic_ctrl pic_ctrl_monitor pic_ctrl_monitor_inst (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_TRAP(I_TRAP), .I_ACK(I_ACK), .I_RETURN(I_RETURN), .I_TDIS(I_TDIS), .O_REQ(O_REQ),
  .O_CPU_LEVEL(O_CPU_LEVEL), .O_RET_VALID(O_RET_VALID));

// File: test/pic_core_model.sv
// behavioural core: acknowledges, returns, runs timed disable
// assumes tasks are called between clock edges
`timescale 1ns/1ns
module pic_core_model
  import pic_pkg::*;
(
  // clock and request
  input  wire logic     i_clk,
  input  wire pic_req_s i_req,
  // core actions
  output logic          o_ack,
  output logic          o_ret,
  output logic          o_tdis,
  output logic [23:0]   o_pc,
  output logic [7:0]    o_srl
);
  initial {o_ack, o_ret, o_tdis, o_pc, o_srl} = 35'h0;
  // acks only a standing request; saved lines inverted once released
  task automatic accept(input logic [23:0] pc, input logic [7:0] status_low_byte);
    logic v;
    v = i_req.valid;
    @(posedge i_clk);
    o_ack <= v;
    o_pc <= pc;
    o_srl <= status_low_byte;
    @(posedge i_clk);
    o_ack <= 1'b0;
    o_pc <= ~pc;
    o_srl <= ~status_low_byte;
  endtask
  task automatic pulse(input logic is_ret);
    @(posedge i_clk);
    o_ret <= is_ret;
    o_tdis <= !is_ret;
    @(posedge i_clk);
    o_ret <= 1'b0;
    o_tdis <= 1'b0;
  endtask
endmodule

// File: test/pic_ctrl_bench.sv
// self-checking bench of the interrupt controller
// assumes pic_core_model plays the core; register tasks drive the port
`timescale 1ns/1ns
`include "pic_defines.svh"
module pic_ctrl_bench
  import pic_pkg::*;
;
  logic clk, rst, wr, rdn, ack, ret, tdis, ret_v, irq;
  logic [5:0] addr;
  pic_word_t wd, rd;
  logic [143:0] src;
  logic [13:0] trap;
  logic [23:0] pc, ret_pc;
  logic [7:0] status_low_byte, ret_srl;
  pic_req_s req;
  pic_lvl_t lvl;
  int fails = 0;
  int compares = 0;
  pic_ctrl #(.NREG(9), .TDIS_CY(16)) pic_ctrl_inst (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wd), .I_WR(wr), .I_RD(rdn), .O_RDATA(rd), .I_SRC(src), .I_TRAP(trap),
    .I_ACK(ack), .I_RETURN(ret), .I_TDIS(tdis), .I_SAVE_PC(pc), .I_SAVE_SRL(status_low_byte),
    .O_REQ(req), .O_CPU_LEVEL(lvl), .O_RET_PC(ret_pc), .O_RET_SRL(ret_srl),
    .O_RET_VALID(ret_v), .O_IRQ(irq));
  pic_core_model pic_core_model_inst (.i_clk(clk), .i_req(req), .o_ack(ack), .o_ret(ret),
    .o_tdis(tdis), .o_pc(pc), .o_srl(status_low_byte));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [5:0] a, input pic_word_t d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [5:0] a, input pic_word_t e);
    @(posedge clk);
    addr <= a;
    rdn <= 1'b1;
    @(posedge clk);
    rdn <= 1'b0;
    @(negedge clk);
    chk("rdata", rd, e);
  endtask
  // two edges cover flag then request registers
  task automatic wait2();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_sim();
    $display("mismatches %0d of %0d compares", fails, compares);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    end_sim();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    {addr, wd, wr, rdn, trap} = 38'h0;
    src = 144'h0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rreg(`PIC_IDX_CTRL2, 16'h8000);
    rreg(`PIC_IDX_CTRL1, 16'h0000);
    rreg(`PIC_IDX_PRI0 + 6'h8, 16'h4444);
    rreg(`PIC_IDX_FLAG0, 16'h0000);
    rreg(`PIC_IDX_ENA0, 16'h0000);
    wreg(`PIC_IDX_PRI0, 16'hffff);
    rreg(`PIC_IDX_PRI0, 16'h7777);
    rreg(6'h3f, 16'h0000);
    wreg(`PIC_IDX_PRI0, 16'h0044);
    @(posedge clk);
    src <= 144'hf;
    @(posedge clk);
    src <= 144'h0;
    rreg(`PIC_IDX_FLAG0, 16'h000f);
    chk("idle", req.valid, 1'b0);
    wreg(`PIC_IDX_ENA0, 16'h000c);
    wait2();
    chk("zero", req.valid, 1'b0);
    wreg(`PIC_IDX_ENA0, 16'h000f);
    wait2();
    chk("tie", req, {1'b1, 4'h4, 8'h08});
    wreg(`PIC_IDX_CTRL2, 16'h0000);
    wait2();
    chk("gie", req.valid, 1'b0);
    wreg(`PIC_IDX_CTRL2, 16'h8000);
    wreg(`PIC_IDX_PRI0, 16'h0064);
    wait2();
    chk("six", req, {1'b1, 4'h6, 8'h09});
    pic_core_model_inst.pulse(1'b0);
    wait2();
    chk("tdis", req.valid, 1'b0);
    wreg(`PIC_IDX_PRI0, 16'h0074);
    wait2();
    chk("seven", req, {1'b1, 4'h7, 8'h09});
    wreg(`PIC_IDX_PRI0, 16'h0064);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("hold", req.valid, 1'b0);
    repeat (14) @(posedge clk);
    @(negedge clk);
    chk("expire", req, {1'b1, 4'h6, 8'h09});
    pic_core_model_inst.accept(24'h123456, 8'ha5);
    @(negedge clk);
    chk("level", lvl, 4'h6);
    wait2();
    chk("lower", req.valid, 1'b0);
    wreg(`PIC_IDX_PRI0, 16'h0067);
    wait2();
    chk("nest", req, {1'b1, 4'h7, 8'h08});
    wreg(`PIC_IDX_CTRL1, 16'h8000);
    wait2();
    chk("nstd", req.valid, 1'b0);
    wreg(`PIC_IDX_CTRL1, 16'h0000);
    wreg(`PIC_IDX_FLAG0, 16'h000e);
    pic_core_model_inst.pulse(1'b1);
    @(negedge clk);
    chk("retv", ret_v, 1'b1);
    chk("retpc", ret_pc, 24'h123456);
    chk("retsrl", ret_srl, 8'ha5);
    wait2();
    chk("oldlvl", lvl, 4'h0);
    chk("again", req, {1'b1, 4'h6, 8'h09});
    chk("masked", irq, 1'b0);
    wreg(`PIC_IDX_IRQMSK, 16'h0004);
    @(negedge clk);
    chk("irq", irq, 1'b1);
    wreg(`PIC_IDX_IRQST, 16'h0004);
    @(negedge clk);
    chk("irqclr", irq, 1'b0);
    wreg(`PIC_IDX_CTRL2, 16'h0000);
    @(posedge clk);
    trap <= 14'h1;
    @(posedge clk);
    trap <= 14'h0;
    wait2();
    chk("trap", req, {1'b1, 4'hf, 8'h00});
    rreg(`PIC_IDX_CTRL1, 16'h0002);
    pic_core_model_inst.accept(24'h00abcd, 8'h3c);
    @(negedge clk);
    chk("traplvl", lvl, 4'hf);
    pic_core_model_inst.pulse(1'b1);
    wait2();
    chk("reenter", req, {1'b1, 4'hf, 8'h00});
    wreg(`PIC_IDX_CTRL1, 16'h0000);
    wait2();
    chk("trapclr", req.valid, 1'b0);
    wreg(`PIC_IDX_CTRL2, 16'h2000);
    wait2();
    chk("swtrap", req, {1'b1, 4'hf, 8'h00});
    end_sim();
  end
endmodule
